/* src/watchdog_params.svh */
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH
`define WDT_CNT_W       32
`define WDT_TIMEOUT_DEF 32'h0001_0000
`define WDT_SYNC_STAGES 3
`define WDT_KICK_IDLE   1'b1
`endif

/* src/watchdog_pkg.sv */
package watchdog_pkg;
  typedef struct packed {
    logic sw_clear;
    logic power_down;
    logic enable;
  } wdt_ctrl_t;

  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_RUN,
    WDT_FIRED
  } wdt_state_t;
endpackage : watchdog_pkg

/* src/module_watchdog_trigger_out.sv */
`timescale 1ns/1ns
`include "watchdog_params.svh"
module module_watchdog_trigger_out #(
  parameter int unsigned CNT_W = `WDT_CNT_W
) (
  // Clock and system reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  // Kick pin from the carrier side, low active, asynchronous
  input  wire logic                    watchdog_kick_n_i,
  // Control and timeout from logic on this clock
  input  wire watchdog_pkg::wdt_ctrl_t ctrl_i,
  input  wire logic [CNT_W-1:0]        timeout_i,
  // Status
  output logic                         watchdog_event_out_o,
  output logic                         running_o
);
  import watchdog_pkg::*;

  // Stages between the pin and the edge detector; the last two must agree
  localparam int unsigned      SYNC_STAGES = `WDT_SYNC_STAGES;
  localparam logic [CNT_W-1:0] TIMEOUT_DEF = CNT_W'(`WDT_TIMEOUT_DEF);
  localparam logic [CNT_W-1:0] COUNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] COUNT_ZERO  = '0;

  // Kick pin path
  logic [SYNC_STAGES-1:0] kick_sync_reg;
  logic                   kick_agree;
  logic                   kick_level_reg;
  logic                   kick_fall;

  // Control decode
  logic                   sw_clear_req;
  logic                   power_down_req;
  logic                   enable_req;
  logic                   clear_all;

  // Timer
  logic [CNT_W-1:0]       timeout_eff;
  logic [CNT_W-1:0]       timeout_last_reg;
  logic                   timeout_hit;
  logic [CNT_W-1:0]       count_reg;

  // Sequencing
  wdt_state_t             state_reg;
  logic                   in_run;
  logic                   in_fired;
  logic                   fire;
  logic                   release_req;

  // Every stage resets to the idle level of the pulled-up pin, so that
  // releasing reset never looks like a falling edge
  genvar stage;
  generate
    for (stage = 0; stage < SYNC_STAGES; stage++) begin : g_kick_sync
      if (stage == 0) begin : g_first
        always_ff @(posedge clock_i) begin
          if (rst_i) begin
            kick_sync_reg[stage] <= `WDT_KICK_IDLE;
          end else begin
            kick_sync_reg[stage] <= watchdog_kick_n_i;
          end
        end
      end else begin : g_next
        always_ff @(posedge clock_i) begin
          if (rst_i) begin
            kick_sync_reg[stage] <= `WDT_KICK_IDLE;
          end else begin
            kick_sync_reg[stage] <= kick_sync_reg[stage-1];
          end
        end
      end
    end
  endgenerate

  // Stage one may still be settling, so only the last two stages are compared
  assign kick_agree = (kick_sync_reg[SYNC_STAGES-1]
                       == kick_sync_reg[SYNC_STAGES-2]);

  // Settled pin level; it only moves once the last two stages agree.
  // A low pulse shorter than two clocks may therefore go unseen.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      kick_level_reg <= `WDT_KICK_IDLE;
    end else if (kick_agree) begin
      kick_level_reg <= kick_sync_reg[SYNC_STAGES-1];
    end
  end

  // Only the high-to-low transition restarts the timer; the rising edge is ignored
  assign kick_fall = kick_level_reg
                     && kick_agree
                     && !kick_sync_reg[SYNC_STAGES-1];

  // Control bits come from logic on this clock and need no synchroniser.
  // Power-down is a level: while it stands the timer is held idle.
  assign sw_clear_req   = ctrl_i.sw_clear;
  assign power_down_req = ctrl_i.power_down;
  assign enable_req     = ctrl_i.enable;
  assign clear_all      = power_down_req;

  // A zero timeout would wrap the limit below, so it falls back to the default length
  assign timeout_eff = (timeout_i == COUNT_ZERO)
                       ? TIMEOUT_DEF
                       : timeout_i;

  // The limit is registered so the wide subtraction stays off the compare path;
  // a new timeout therefore takes effect one cycle later
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timeout_last_reg <= TIMEOUT_DEF - COUNT_ONE;
    end else begin
      timeout_last_reg <= timeout_eff - COUNT_ONE;
    end
  end

  // Count runs from zero, so the last count of a period is timeout minus one
  assign timeout_hit = (count_reg >= timeout_last_reg);

  assign in_run   = (state_reg == WDT_RUN);
  assign in_fired = (state_reg == WDT_FIRED);

  // A kick landing in the very cycle of expiry still counts as in time
  assign fire = in_run
                && enable_req
                && !kick_fall
                && timeout_hit;

  // A clear outside the fired state does nothing, so a held clear cannot mask a timeout
  assign release_req = in_fired && sw_clear_req;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= WDT_IDLE;
    end else if (clear_all) begin
      state_reg <= WDT_IDLE;
    end else begin
      unique case (state_reg)
        WDT_IDLE: begin
          // Arming starts a full period from zero
          if (enable_req) begin
            state_reg <= WDT_RUN;
          end
        end
        WDT_RUN: begin
          if (!enable_req) begin
            // Disarming is not a missed kick and raises no event
            state_reg <= WDT_IDLE;
          end else if (fire) begin
            state_reg <= WDT_FIRED;
          end
        end
        WDT_FIRED: begin
          // Held until software clears; a kick alone does not release it
          if (sw_clear_req) begin
            if (enable_req) begin
              state_reg <= WDT_RUN;
            end else begin
              state_reg <= WDT_IDLE;
            end
          end
        end
        default: begin
          // The fourth code of the two-bit state is unused
          state_reg <= WDT_IDLE;
        end
      endcase
    end
  end

  // Outside RUN the counter rests at zero, so every arming starts a full period
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_reg <= COUNT_ZERO;
    end else if (clear_all) begin
      count_reg <= COUNT_ZERO;
    end else if (!in_run) begin
      count_reg <= COUNT_ZERO;
    end else if (kick_fall) begin
      // A settled falling edge restarts the period
      count_reg <= COUNT_ZERO;
    end else begin
      count_reg <= count_reg + COUNT_ONE;
    end
  end

  // The event flop is itself the pending missed-kick indication;
  // it is low whenever nothing is pending
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      watchdog_event_out_o <= 1'b0;
    end else if (clear_all) begin
      watchdog_event_out_o <= 1'b0;
    end else if (fire) begin
      watchdog_event_out_o <= 1'b1;
    end else if (release_req) begin
      watchdog_event_out_o <= 1'b0;
    end
  end

  // Outside power-down it follows the state one cycle late, so that the output comes from a flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      running_o <= 1'b0;
    end else if (clear_all) begin
      running_o <= 1'b0;
    end else if (in_run) begin
      running_o <= 1'b1;
    end else begin
      running_o <= 1'b0;
    end
  end

endmodule : module_watchdog_trigger_out

/* test/kick_source.sv */
`timescale 1ns/1ns
module kick_source (
  input  wire logic clock_i,
  input  wire logic active_i,
  output logic      kick_n_o = 1'b1
);
  logic [2:0] phase_reg = 3'h0;
  always @(negedge clock_i) begin
    phase_reg <= active_i ? phase_reg + 3'h1 : 3'h0;
    kick_n_o  <= !(active_i && phase_reg[2]);
  end
endmodule : kick_source

/* test/module_watchdog_trigger_out_chk.sv */
`timescale 1ns/1ns
module module_watchdog_trigger_out_chk
  import watchdog_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input wire logic             clock_i,
  input wire logic             rst_i,
  input wire logic             watchdog_kick_n_i,
  input wire logic             watchdog_event_out_o,
  input wire logic             running_o,
  input wire wdt_ctrl_t        ctrl_i,
  input wire logic [CNT_W-1:0] timeout_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_reset_clears: assert property ($fell(rst_i) |-> !watchdog_event_out_o)
    else $error("event set after reset");
  a_pwrdn_clears: assert property (ctrl_i.power_down |=> !watchdog_event_out_o)
    else $error("event kept in power-down");
  a_event_holds: assert property (watchdog_event_out_o && !ctrl_i.sw_clear
    && !ctrl_i.power_down |=> watchdog_event_out_o) else $error("event dropped");
  a_clear_drops: assert property (watchdog_event_out_o && ctrl_i.sw_clear
    |=> !watchdog_event_out_o) else $error("clear ignored");
  a_rise_cause: assert property ($rose(watchdog_event_out_o) |-> $past(running_o))
    else $error("event without running timer");
endmodule : module_watchdog_trigger_out_chk

/* test/module_watchdog_trigger_out_tb_top.sv */
`timescale 1ns/1ns
module module_watchdog_trigger_out_tb_top;
  import watchdog_pkg::*;
  logic      clock_i     = 1'b0;
  logic      rst_i       = 1'b1;
  logic      kick_on     = 1'b0;
  logic      kick_n;
  logic      ev;
  logic      run_o;
  wdt_ctrl_t ctrl        = '0;
  int        err_total   = 0;
  int        check_count = 0;
  `define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", name, exp, got); end end
  always #4 clock_i = ~clock_i;
  kick_source kick_source_i (
    .clock_i  (clock_i),
    .active_i (kick_on),
    .kick_n_o (kick_n)
  );
  module_watchdog_trigger_out module_watchdog_trigger_out_i (
    .clock_i              (clock_i),
    .rst_i                (rst_i),
    .watchdog_kick_n_i    (kick_n),
    .ctrl_i               (ctrl),
    .timeout_i            (32'h0000_0010),
    .watchdog_event_out_o (ev),
    .running_o            (run_o)
  );
  task automatic run(input int n); repeat (n) @(negedge clock_i); endtask : run
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic expire();
    for (int i = 0; i < 40 && ev !== 1'b1; i++) run(1);
    if (ev !== 1'b1) begin
      err_total++;
      $display("unexpected event exp 1 got %0h", ev);
      finish_test();
    end
  endtask : expire
  task automatic missed_kick();
    ctrl.enable = 1'b1;
    run(10);
    `CHK("event", 1'b0, ev)
    `CHK("running", 1'b1, run_o)
    expire();
    run(6);
    `CHK("event", 1'b1, ev)
    ctrl.sw_clear = 1'b1;
    run(1);
    ctrl.sw_clear = 1'b0;
    run(1);
    `CHK("event", 1'b0, ev)
  endtask : missed_kick
  task automatic kicked();
    kick_on = 1'b1;
    run(60);
    `CHK("event", 1'b0, ev)
    kick_on = 1'b0;
    expire();
    kick_on = 1'b1;
    run(20);
    `CHK("event", 1'b1, ev)
  endtask : kicked
  task automatic power_off();
    kick_on = 1'b0;
    ctrl.power_down = 1'b1;
    run(2);
    `CHK("event", 1'b0, ev)
    `CHK("running", 1'b0, run_o)
    ctrl.power_down = 1'b0;
    expire();
    rst_i = 1'b1;
    run(2);
    `CHK("event", 1'b0, ev)
    `CHK("running", 1'b0, run_o)
    rst_i = 1'b0;
    run(2);
    `CHK("event", 1'b0, ev)
  endtask : power_off
  initial begin
    run(4);
    rst_i = 1'b0;
    missed_kick();
    kicked();
    power_off();
    finish_test();
  end
endmodule : module_watchdog_trigger_out_tb_top
bind module_watchdog_trigger_out module_watchdog_trigger_out_chk #(.CNT_W(CNT_W)) chk_i (
  .clock_i(clock_i), .rst_i(rst_i), .watchdog_kick_n_i(watchdog_kick_n_i), .ctrl_i(ctrl_i),
  .timeout_i(timeout_i), .watchdog_event_out_o(watchdog_event_out_o), .running_o(running_o));
